// ### rtl/spib_pkg.sv
/*
  Shared constants and types for the buffered SPI master/slave block:
  register offsets, field positions, reset values, engine states.
  Assumes an 8-bit register port with byte-wide data.
*/
package spib_pkg;
  localparam int SPIB_BYTE_W = 8;
  typedef logic [SPIB_BYTE_W-1:0] spib_byte_t;
  typedef logic [2:0] spib_rate_t;
  typedef logic [3:0] spib_edge_t;

  // register offsets
  localparam spib_byte_t ADDR_STAT = 8'h84;
  localparam spib_byte_t ADDR_CTRL = 8'h85;
  localparam spib_byte_t ADDR_DATA = 8'h86;

  // reset values
  localparam spib_byte_t CTRL_RST = 8'h04;
  localparam spib_byte_t DATA_RST = 8'h00;
  localparam logic STAT_FLAG_RST = 1'b0;

  // control fields
  localparam int BIT_IGNORE_SELECT = 7;
  localparam int BIT_ENABLE = 6;
  localparam int BIT_ORDER = 5;
  localparam int BIT_MASTER = 4;
  localparam int BIT_CPOL = 3;
  localparam int BIT_CPHA = 2;
  localparam int BIT_RATE1 = 1;
  localparam int BIT_RATE0 = 0;

  // status fields
  localparam int BIT_COMPLETE = 7;
  localparam int BIT_COLLISION = 6;
  localparam int BIT_HOLD_FULL = 5;
  localparam int BIT_BUSY = 4;
  localparam int BIT_RATE2 = 0;

  // bit clock timing
  localparam int SYSCLK_HALF_BASE = 2;
  localparam int OVF_PER_HALF = 3;
  localparam spib_rate_t RATE_UART1 = 3'h6;
  localparam spib_edge_t EDGE_LAST = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_FINAL = 2'b11,
    ST_DONE = 2'b10
  } spib_state_t;
endpackage

// ### rtl/spib_sh_if.sv
/*
  Carrier between the engine and its byte shifter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface spib_sh_if #(parameter int W = 8);
  logic load;
  logic [W-1:0] load_byte;
  logic sample;
  logic shift;
  logic din;
  logic lsb_first;
  logic [W-1:0] byte_q;
  logic dout;
  modport ctl (output load, load_byte, sample, shift, din, lsb_first, input byte_q, dout);
  modport shf (input load, load_byte, sample, shift, din, lsb_first, output byte_q, dout);
endinterface

// ### rtl/spib_clkgen.sv
/*
  Master bit clock generator: one tick per half bit period.
  Assumes overflow inputs are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
module spib_clkgen #(
  parameter int CW = 7
) (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic run, // count while high
  input wire spib_pkg::spib_rate_t rate, // rate select code
  input wire logic uart_ovf, // uart1 baud timer overflow pulse
  input wire logic t3_ovf, // timer3 overflow pulse
  input wire logic t3_lo_ovf, // timer3 low byte overflow pulse
  input wire logic t3_split, // timer3 in split mode
  output logic tick // half bit period pulse
);
  import spib_pkg::*;

  if (CW < 6) begin : g_bad_width
    $error("spib_clkgen: CW too small for the slowest divider");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] limit;
  logic src_ev;

  // divide selection, see [RULE6]
  assign limit = (rate < RATE_UART1) ? CW'((SYSCLK_HALF_BASE << rate) - 1) :
                                       CW'(OVF_PER_HALF - 1);
  // split timer uses low byte overflow, see [RULE7]
  assign src_ev = (rate < RATE_UART1) ? 1'b1 :
                  (rate == RATE_UART1) ? uart_ovf :
                  (t3_split ? t3_lo_ovf : t3_ovf);
  assign tick = run & src_ev & (cnt_q == limit);

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      cnt_q <= '0;
    end else if (src_ev) begin
      cnt_q <= (cnt_q == limit) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule

// ### rtl/spib_shifter.sv
/*
  Byte shift register with selectable bit order.
  Assumes load and shift never come in the same cycle.
*/
`timescale 1ns/1ps
module spib_shifter #(
  parameter int W = 8
) (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  spib_sh_if.shf sh // engine side
);
  import spib_pkg::*;

  if (W < 2) begin : g_bad_width
    $error("spib_shifter: W must be at least 2");
  end

  logic [W-1:0] sr_q;
  logic smp_q;

  // order control, see [RULE10]
  assign sh.dout = sh.lsb_first ? sr_q[0] : sr_q[W-1];
  assign sh.byte_q = sr_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sr_q <= '0;
      smp_q <= 1'b0;
    end else begin
      if (sh.sample) begin
        smp_q <= sh.din;
      end
      if (sh.load) begin
        sr_q <= sh.load_byte;
      end else if (sh.shift) begin
        sr_q <= sh.lsb_first ? {smp_q, sr_q[W-1:1]} : {sr_q[W-2:0], smp_q};
      end
    end
  end
endmodule

// ### rtl/spib_top.sv
/*
  Buffered SPI master/slave: register port, holding buffer, engine,
  pin drive. Assumes pin inputs synchronous to ref_clk and overflow
  inputs one cycle long.
*/
// Implementation choice: the address-and-strobe port.
// Functional notes
// [RULE1] write into empty holding buffer sets full
// [RULE2] empty shift register takes buffered byte at once
// [RULE3] master starts on loaded byte, slave waits
// [RULE4] write while full dropped, sets collision flag
// [RULE5] collision flag cleared only by writing one
// [RULE6] rate code selects sysclk or overflow divider
// [RULE7] split timer3 uses low byte overflow
// [RULE8] ignore-select chooses pin or master bit
// [RULE9] enable low releases all pins
// [RULE10] bit order: msb first or lsb first
// [RULE11] master bit selects slave or master
// [RULE12] polarity sets clock idle level
// [RULE13] phase zero: sample leading, change trailing
// [RULE14] phase one: drive leading, sample trailing
// [RULE15] completion flag set at byte end
// [RULE16] completion flag set on forced role change
// [RULE17] completion flag cleared only by writing one
// [RULE18] holding full flag read-only, hardware driven
// [RULE19] busy while transferring or shift register loaded
// [RULE20] software writes zero to reserved status bits
// [RULE21] status bit zero is rate msb
// [RULE22] separate transmit and receive data buffers
// [RULE23] select low as master clears master bit
// [RULE24] clock stops after one byte, exchange
// [RULE25] slave timing only from external clock
`timescale 1ns/1ps
module spib_top #(
  parameter int RATE_CW = 7
) (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire spib_pkg::spib_byte_t reg_addr, // register address
  input wire spib_pkg::spib_byte_t reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output spib_pkg::spib_byte_t reg_rdata, // read data, cycle after strobe
  input wire logic serial_clock_pin_level, // clock pin level
  output logic serial_clock_pin_drive, // clock pin drive value
  output logic serial_clock_pin_oe_n, // clock pin enable, low drives
  input wire logic mosi_level, // master-out pin level
  output logic mosi_drive, // master-out drive value
  output logic mosi_oe_n, // master-out enable, low drives
  input wire logic miso_level, // master-in pin level
  output logic miso_drive, // master-in drive value
  output logic miso_oe_n, // master-in enable, low drives
  input wire logic slave_select_input_n, // slave select pin
  input wire logic uart1_baud_timer_overflow, // overflow pulse
  input wire logic timer3_overflow, // overflow pulse
  input wire logic timer3_low_byte_overflow, // overflow pulse
  input wire logic timer3_split_mode, // timer3 split mode level
  output logic pins_claimed, // high: pins owned by the interface
  output logic complete_req // completion flag level for irq logic
);
  import spib_pkg::*;

  spib_byte_t ctrl_q;
  spib_byte_t ctrl_d;
  spib_byte_t ctrl_wr_val;
  spib_byte_t thr_q;
  spib_byte_t rx_q;
  spib_byte_t rdata_q;
  spib_byte_t stat_val;
  spib_byte_t rd_val;
  logic rate_select_bit2_q;
  logic transfer_complete_flag_q;
  logic write_collision_flag_q;
  logic holding_full_flag_q;
  logic osr_full_q;
  logic phase_q;
  logic sclk_prev_q;
  spib_edge_t cnt_q;
  spib_state_t state_q;
  spib_state_t state_d;

  spib_sh_if #(.W(SPIB_BYTE_W)) sh ();

  // register decode
  wire wr_stat = reg_wr & (reg_addr == ADDR_STAT);
  wire wr_ctrl = reg_wr & (reg_addr == ADDR_CTRL);
  wire wr_data = reg_wr & (reg_addr == ADDR_DATA);

  wire en = ctrl_q[BIT_ENABLE];
  wire ignore_select_pin = ctrl_q[BIT_IGNORE_SELECT];
  wire master_select = ctrl_q[BIT_MASTER];
  wire cpol = ctrl_q[BIT_CPOL];
  wire cpha = ctrl_q[BIT_CPHA];
  wire spib_rate_t rate = {rate_select_bit2_q, ctrl_q[BIT_RATE1], ctrl_q[BIT_RATE0]};

  // role resolution, see [RULE8] [RULE11]
  wire mode_chg = en & master_select & !ignore_select_pin & !slave_select_input_n;
  wire role_master = en & master_select & !mode_chg;
  wire selected = en & !master_select & (ignore_select_pin | !slave_select_input_n);

  wire running = (state_q == ST_SHIFT);
  wire idle = (state_q == ST_IDLE);
  wire final_st = (state_q == ST_FINAL);
  wire done = (state_q == ST_DONE);
  wire busy = osr_full_q | !idle;
  wire tick;

  // master edges from the divider
  wire m_lead = tick & !phase_q;
  wire m_trail = tick & phase_q;
  // slave edges from the external clock only, see [RULE25]
  wire lvl_now = serial_clock_pin_level ^ cpol;
  wire lvl_prev = sclk_prev_q ^ cpol;
  wire s_ok = selected & (idle | running);
  wire s_lead = s_ok & lvl_now & !lvl_prev;
  wire s_trail = s_ok & !lvl_now & lvl_prev;

  wire ev_lead = role_master ? m_lead : s_lead;
  wire ev_trail = role_master ? m_trail : s_trail;
  wire ev_edge = ev_lead | ev_trail;
  wire last_edge = ev_edge & (cnt_q == EDGE_LAST);

  // master kicks off on loaded shift register, see [RULE3]
  wire start = role_master & osr_full_q & idle;
  wire abort = !en | (running & (mode_chg | (!role_master & !selected)));
  // holding buffer to shift register, see [RULE2]
  wire move_ok = holding_full_flag_q & !busy & !ev_edge;
  wire wr_accept = wr_data & !holding_full_flag_q;
  wire wr_collide = wr_data & holding_full_flag_q;

  // sampling and shifting per phase, see [RULE13] [RULE14]
  assign sh.sample = cpha ? ev_trail : ev_lead;
  assign sh.shift = cpha ? ((ev_lead & (cnt_q != '0)) | final_st) : ev_trail;
  assign sh.load = move_ok;
  assign sh.load_byte = thr_q;
  assign sh.din = role_master ? miso_level : mosi_level;
  assign sh.lsb_first = ctrl_q[BIT_ORDER];

  spib_shifter #(.W(SPIB_BYTE_W)) u_shifter (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sh(sh)
  );

  spib_clkgen #(.CW(RATE_CW)) u_clkgen (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(role_master & running),
    .rate(rate),
    .uart_ovf(uart1_baud_timer_overflow),
    .t3_ovf(timer3_overflow),
    .t3_lo_ovf(timer3_low_byte_overflow),
    .t3_split(timer3_split_mode),
    .tick(tick)
  );

  // engine sequence: clock stops after one byte, see [RULE24]
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start || ev_edge) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (last_edge) begin
          state_d = ST_FINAL;
        end
      end
      ST_FINAL: begin
        state_d = ST_DONE;
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (abort) begin
      state_d = ST_IDLE;
    end
  end

  // hardware clears master bit on forced role change, see [RULE23]
  assign ctrl_wr_val = wr_ctrl ? reg_wdata : ctrl_q;
  always_comb begin
    ctrl_d = ctrl_wr_val;
    ctrl_d[BIT_MASTER] = ctrl_wr_val[BIT_MASTER] & !mode_chg;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      phase_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= (abort || last_edge) ? '0 : (ev_edge ? cnt_q + 1'b1 : cnt_q);
      phase_q <= (role_master & running) ? (phase_q ^ tick) : 1'b0;
      sclk_prev_q <= serial_clock_pin_level;
    end
  end

  // registers and flags; hardware set wins over software clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
      rate_select_bit2_q <= STAT_FLAG_RST;
      transfer_complete_flag_q <= STAT_FLAG_RST;
      write_collision_flag_q <= STAT_FLAG_RST;
      holding_full_flag_q <= STAT_FLAG_RST;
      thr_q <= DATA_RST;
      rx_q <= DATA_RST;
      osr_full_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      // rate msb, see [RULE21]
      rate_select_bit2_q <= wr_stat ? reg_wdata[BIT_RATE2] : rate_select_bit2_q;
      // completion flag, see [RULE15] [RULE16] [RULE17]
      transfer_complete_flag_q <= done | mode_chg | (transfer_complete_flag_q & !(wr_stat & reg_wdata[BIT_COMPLETE]));
      // collision flag, see [RULE4] [RULE5]
      write_collision_flag_q <= wr_collide | (write_collision_flag_q & !(wr_stat & reg_wdata[BIT_COLLISION]));
      // holding buffer, see [RULE1] [RULE18]
      if (wr_accept) begin
        thr_q <= reg_wdata;
        holding_full_flag_q <= 1'b1;
      end else if (move_ok) begin
        holding_full_flag_q <= 1'b0;
      end
      if (move_ok) begin
        osr_full_q <= 1'b1;
      end else if (done || abort) begin
        osr_full_q <= 1'b0;
      end
      // receive buffer apart from transmit path, see [RULE22]
      if (done) begin
        rx_q <= sh.byte_q;
      end
    end
  end

  // read path; reserved status bits read zero, see [RULE19] [RULE20]
  always_comb begin
    stat_val = '0;
    stat_val[BIT_COMPLETE] = transfer_complete_flag_q;
    stat_val[BIT_COLLISION] = write_collision_flag_q;
    stat_val[BIT_HOLD_FULL] = holding_full_flag_q;
    stat_val[BIT_BUSY] = busy;
    stat_val[BIT_RATE2] = rate_select_bit2_q;
  end
  assign rd_val = (reg_addr == ADDR_STAT) ? stat_val :
                  (reg_addr == ADDR_CTRL) ? ctrl_q :
                  (reg_addr == ADDR_DATA) ? rx_q : '0;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_val : '0;
    end
  end
  assign reg_rdata = rdata_q;

  // pin drive; clock idles at polarity level, see [RULE9] [RULE12]
  wire drive_master = role_master & (ignore_select_pin | running);
  assign serial_clock_pin_drive = cpol ^ (running & phase_q);
  assign serial_clock_pin_oe_n = !drive_master;
  assign mosi_drive = sh.dout;
  assign mosi_oe_n = !drive_master;
  assign miso_drive = sh.dout;
  assign miso_oe_n = !selected;
  assign pins_claimed = en;
  assign complete_req = transfer_complete_flag_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_hold_load_sets: assert property ( // see [RULE1]
    wr_data && !holding_full_flag_q |=> holding_full_flag_q && thr_q == $past(reg_wdata))
    else $error("holding buffer write not taken");
  chk_hold_to_shift: assert property ( // see [RULE2]
    holding_full_flag_q && !busy && !ev_edge |=> !holding_full_flag_q && osr_full_q)
    else $error("holding byte not moved");
  chk_master_start: assert property ( // see [RULE3]
    start |=> running)
    else $error("master did not start");
  chk_collision_keeps: assert property ( // see [RULE4]
    wr_data && holding_full_flag_q |=> write_collision_flag_q && thr_q == $past(thr_q))
    else $error("collision write not handled");
  chk_collision_sticky: assert property ( // see [RULE5]
    write_collision_flag_q && !(wr_stat && reg_wdata[BIT_COLLISION]) |=> write_collision_flag_q)
    else $error("collision flag lost");
  chk_pins_released: assert property ( // see [RULE9]
    !en |-> serial_clock_pin_oe_n && mosi_oe_n && miso_oe_n)
    else $error("pins driven while disabled");
  chk_clock_idle: assert property ( // see [RULE12]
    !running |-> serial_clock_pin_drive == cpol)
    else $error("clock not at idle level");
  chk_clock_toggle: assert property ( // see [RULE24]
    tick && !abort && !wr_ctrl |=> serial_clock_pin_drive != $past(serial_clock_pin_drive))
    else $error("clock pin did not follow tick");
  chk_done_flag: assert property ( // see [RULE15]
    final_st |=> done ##1 transfer_complete_flag_q)
    else $error("completion flag not set");
  chk_role_change: assert property ( // see [RULE23]
    mode_chg |=> !master_select && transfer_complete_flag_q)
    else $error("role change not applied");
  chk_busy_loaded: assert property ( // see [RULE19]
    osr_full_q || running |-> stat_val[BIT_BUSY])
    else $error("busy low during transfer");
endmodule

// ### tb/spib_slave_model.sv
/*
  External SPI slave used as the far side of the bench: one byte shift
  register exchanged with the master. Assumes mode inputs stay put while
  selected.
*/
`timescale 1ns/1ps
module spib_slave_model (
  input wire logic sclk, // serial clock wire
  input wire logic mosi, // data from master
  input wire logic ss_n, // select, active low
  input wire logic cpol, // clock idle level
  input wire logic cpha, // clock phase
  input wire logic lsb, // lsb first
  output logic miso // data to master
);
  logic [7:0] sr = 8'h00;
  logic smp = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic out_bit;

  task automatic preset(input logic [7:0] v);
    sr = v;
    cnt = 4'h0;
  endtask

  function automatic logic [7:0] shin(input logic [7:0] s, input logic b);
    return lsb ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  always @(sclk) begin
    if (!ss_n) begin
      if (sclk != cpol) begin
        if (!cpha) smp = mosi;
        else if (cnt != 4'h0) sr = shin(sr, smp);
      end else begin
        if (cpha) smp = mosi;
        cnt = cnt + 4'h1;
        if (!cpha || cnt == 4'h8) sr = shin(sr, smp);
        if (cnt == 4'h8) cnt = 4'h0;
      end
    end
  end

  assign out_bit = lsb ? sr[0] : sr[7];
  // released line shows the inverse rather than a stale value
  assign miso = ss_n ? ~out_bit : out_bit;
endmodule

// ### tb/testbench.sv
/*
  Self-checking bench for the buffered SPI block in master and slave roles, with
  a slave model on the far side. Assumes the register port answers one cycle after a read.
*/
`timescale 1ns/1ps
module testbench;
  import spib_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  spib_byte_t reg_addr = 8'h00;
  spib_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  spib_byte_t reg_rdata, st, tx, sv, a, b;
  logic sck_drive, sck_oe_n, mosi_drive, mosi_oe_n, miso_drive, miso_oe_n;
  logic dsel_n = 1'b1;
  logic uovf = 1'b0;
  logic t3ovf = 1'b0;
  logic t3lo = 1'b0;
  logic t3spl = 1'b0;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic lsb = 1'b0;
  logic ss_n = 1'b1;
  logic tb_sck = 1'b0;
  logic claimed, creq, sclk_w, mosi_w, miso_w;
  spib_rate_t r;
  spib_rate_t rates [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
  int err_count = 0;
  int num_checks = 0;

  always #2.5 ref_clk = ~ref_clk;
  // released lines: clock from the bench master, data pulled high
  assign sclk_w = sck_oe_n ? tb_sck : sck_drive;
  assign mosi_w = mosi_oe_n ? 1'b1 : mosi_drive;

  always @(posedge ref_clk) begin
    uovf <= ($urandom_range(3) == 0);
    t3ovf <= ($urandom_range(3) == 0);
    t3lo <= ($urandom_range(3) == 0);
  end

  spib_top #(.RATE_CW(7)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_clock_pin_level(sclk_w), .serial_clock_pin_drive(sck_drive),
    .serial_clock_pin_oe_n(sck_oe_n), .mosi_level(mosi_w), .mosi_drive(mosi_drive),
    .mosi_oe_n(mosi_oe_n), .miso_level(miso_w), .miso_drive(miso_drive),
    .miso_oe_n(miso_oe_n), .slave_select_input_n(dsel_n),
    .uart1_baud_timer_overflow(uovf), .timer3_overflow(t3ovf),
    .timer3_low_byte_overflow(t3lo), .timer3_split_mode(t3spl),
    .pins_claimed(claimed), .complete_req(creq));

  spib_slave_model slv (
    .sclk(sclk_w), .mosi(mosi_w), .ss_n(ss_n), .cpol(cpol), .cpha(cpha), .lsb(lsb),
    .miso(miso_w));

  function automatic spib_byte_t ctrl_of(input logic ign, en, l, m, p, h,
                                         input spib_rate_t rt);
    return {ign, en, l, m, p, h, rt[1:0]};
  endfunction

  task automatic chk(input spib_byte_t got, exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input spib_byte_t ad, d);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input spib_byte_t ad, output spib_byte_t d);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rdchk(input spib_byte_t ad, exp);
    spib_byte_t d;
    rd(ad, d);
    chk(d, exp);
  endtask

  // poll until the flag is up and the engine and buffer are empty
  task automatic wait_done();
    spib_byte_t d;
    int n;
    n = 0;
    d = 8'h00;
    while ((d[7] !== 1'b1 || d[5:4] !== 2'b00) && n < 3000) begin
      rd(ADDR_STAT, d);
      n++;
    end
    if (n >= 3000) chk(d, 8'h80);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h1690));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdchk(ADDR_CTRL, CTRL_RST);
    rdchk(ADDR_STAT, 8'h00);
    rdchk(ADDR_DATA, DATA_RST);
    rdchk(8'h87, 8'h00);
    chk({claimed, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h07);
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      tx = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : spib_byte_t'($urandom);
      sv = spib_byte_t'($urandom);
      r = rates[i % 5];
      wr(ADDR_CTRL, ctrl_of(1'b1, 1'b1, i[0], 1'b1, i[1], i[2], r));
      @(posedge ref_clk);
      lsb <= i[0];
      cpol <= i[1];
      cpha <= i[2];
      t3spl <= 1'($urandom);
      ss_n <= 1'b0;
      slv.preset(sv);
      wr(ADDR_STAT, {7'h00, r[2]});
      wr(ADDR_DATA, tx);
      wait_done();
      rdchk(ADDR_STAT, {7'h40, r[2]});
      rdchk(ADDR_DATA, sv);
      chk(slv.sr, tx);
      wr(ADDR_STAT, {7'h00, r[2]});
      rdchk(ADDR_STAT, {7'h40, r[2]});
      wr(ADDR_STAT, {7'h40, r[2]});
      rdchk(ADDR_STAT, {7'h00, r[2]});
      @(posedge ref_clk);
      ss_n <= 1'b1;
    end
    $display("test master exchange done");

    a = spib_byte_t'($urandom);
    b = spib_byte_t'($urandom);
    wr(ADDR_STAT, 8'h00);
    wr(ADDR_CTRL, ctrl_of(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 3'h2));
    @(posedge ref_clk);
    lsb <= 1'b0;
    cpol <= 1'b0;
    cpha <= 1'b1;
    ss_n <= 1'b0;
    slv.preset(8'h3C);
    wr(ADDR_DATA, a);
    repeat (3) @(posedge ref_clk);
    rdchk(ADDR_STAT, 8'h10);
    wr(ADDR_DATA, b);
    rdchk(ADDR_STAT, 8'h30);
    wr(ADDR_DATA, ~b);
    rdchk(ADDR_STAT, 8'h70);
    wr(ADDR_STAT, 8'h30);
    rdchk(ADDR_STAT, 8'h70);
    wr(ADDR_STAT, 8'h40);
    rdchk(ADDR_STAT, 8'h30);
    wait_done();
    rdchk(ADDR_DATA, a);
    chk(slv.sr, b);
    wr(ADDR_STAT, 8'h80);
    @(posedge ref_clk);
    ss_n <= 1'b1;
    $display("test holding buffer done");

    // slave role: bench clocks 16 edges, master-out rests high
    wr(ADDR_CTRL, 8'hC4);
    wr(ADDR_DATA, spib_byte_t'($urandom));
    for (int e = 0; e < 16; e++) begin
      @(posedge ref_clk);
      tb_sck <= ~tb_sck;
      repeat (2) @(posedge ref_clk);
    end
    wait_done();
    rdchk(ADDR_DATA, 8'hFF);
    wr(ADDR_STAT, 8'h80);
    $display("test slave role done");

    wr(ADDR_CTRL, 8'h54);
    @(posedge ref_clk);
    dsel_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rdchk(ADDR_CTRL, 8'h44);
    rdchk(ADDR_STAT, 8'h80);
    chk({creq, sck_oe_n, miso_oe_n}, 8'h06);
    @(posedge ref_clk);
    dsel_n <= 1'b1;
    wr(ADDR_STAT, 8'h80);
    wr(ADDR_CTRL, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk({claimed, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h07);
    $display("test role change done");
    end_of_test();
  end
endmodule
